// [pcc_device.sv]
// device end: pll clock configuration registers behind the serial link
//
// What this block does
// RL1: any write to address 0x00 resets device
// RL2: read 0x00 returns low identification byte
// RL3: 0x01 read-only, returns high identification byte
// RL4: 22-bit fraction spread over 0x03, 0x04, 0x05
// RL5: host sets fraction as receiver clocking needs
// RL6: host keeps integer ratio 5..13, near 8
// RL7: host sets integer as receiver clocking needs
// RL8: bit 4 halves oscillator into pll
// RL9: no override: validity 0, or copied from receiver
// RL10: override sends bit 5 and bit 6 validity
// RL11: post-divider select, reset 10, auto in receive
// RL12: bit 2 picks integer or fractional pll
// RL13: host keeps fractional mode in receive mode
// RL14: master divider only with pll clock b source
// RL15: aux divider, reset 01, only with clock a
// RL16: master source: 0 pll clock b, 1 oscillator
// RL17: aux source: 0 pll clock a, 1 oscillator
// RL18: host writes zero to unused bits
// RL19: reset write data ignored, registers to defaults
module pcc_device (
  input wire logic clk,
  input wire logic rst_n,
  pcc_link_if.device link,
  input wire logic rx_mode,
  input wire logic [1:0] rx_post_divider,
  input wire logic tx_source_is_receiver,
  input wire logic rx_validity,
  input wire logic master_clock_out_source,
  input wire logic aux_clock_source,
  output logic device_reset_pulse,
  output logic [21:0] pll_fraction,
  output logic [3:0] pll_integer,
  output logic pll_input_halver,
  output logic fractional_pll_enable,
  output logic [1:0] pll_post_divider_select,
  output logic master_clock_out_divider,
  output logic [1:0] aux_clock_out_divider,
  output logic tx_validity_first_subframe,
  output logic tx_validity_second_subframe,
  output logic master_clock_uses_osc,
  output logic aux_clock_uses_osc
);

  typedef struct packed {
    logic [7:0] frac_low;
    logic [7:0] frac_mid;
    logic [5:0] frac_high;
    logic [7:0] int_valid;
    logic [5:0] div_select;
    logic sclk_prev;
    logic [3:0] bit_cnt;
    logic [15:0] shift_in;
    logic [7:0] shift_out;
    logic reading;
    logic reset_pulse;
    logic [21:0] frac_eff;
    logic val_sf0;
    logic val_sf1;
    logic mdiv_eff;
    logic [1:0] adiv_eff;
    logic mclk_osc;
    logic aux_osc;
  } pcc_dev_st_t;

  localparam pcc_dev_st_t RST_STATE = '{
    frac_low: pcc_pkg::RST_FRAC_LOW,
    frac_mid: pcc_pkg::RST_FRAC_MID,
    frac_high: pcc_pkg::RST_FRAC_HIGH,
    int_valid: pcc_pkg::RST_INT_VALID,
    div_select: pcc_pkg::RST_DIV_SELECT,
    sclk_prev: 1'b0,
    bit_cnt: 4'h0,
    shift_in: 16'h0000,
    shift_out: 8'h00,
    reading: 1'b0,
    reset_pulse: 1'b0,
    frac_eff: 22'h000000,
    val_sf0: 1'b0,
    val_sf1: 1'b0,
    mdiv_eff: 1'b0,
    adiv_eff: 2'h0,
    mclk_osc: 1'b0,
    aux_osc: 1'b0
  };

  pcc_dev_st_t st_q;
  pcc_dev_st_t st_d;

  logic sclk_rise;
  logic [15:0] word;
  logic [6:0] waddr;
  logic [7:0] wdata;
  logic [6:0] raddr;
  logic [7:0] rdata;

  assign sclk_rise = link.sclk & ~st_q.sclk_prev & ~link.cs_n;
  assign word = {st_q.shift_in[14:0], link.sdin};
  assign waddr = word[15:9];
  assign wdata = word[7:0];
  assign raddr = st_q.shift_in[6:0];

  // ----------------------------------------------------------------
  // read data select, only identification is readable
  // ----------------------------------------------------------------
  always_comb begin
    unique case (raddr)
      pcc_pkg::ADDR_RESET_ID_LOW: rdata = pcc_pkg::ID_LOW_CODE; // RL2
      pcc_pkg::ADDR_ID_HIGH: rdata = pcc_pkg::ID_HIGH_CODE; // RL3
      pcc_pkg::ADDR_REVISION: rdata = {4'h0, pcc_pkg::REVISION_CODE};
      default: rdata = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    st_d.sclk_prev = link.sclk;
    st_d.reset_pulse = 1'b0;

    // serial framing
    if (link.cs_n) begin
      st_d.bit_cnt = 4'h0;
      st_d.reading = 1'b0;
    end else if (sclk_rise) begin
      st_d.shift_in = word;
      st_d.bit_cnt = st_q.bit_cnt + 4'h1;
      if (st_q.reading) begin
        st_d.shift_out = {st_q.shift_out[6:0], 1'b0};
      end
      if (st_q.bit_cnt == pcc_pkg::RW_BIT && link.sdin) begin
        st_d.reading = 1'b1;
        st_d.shift_out = rdata;
      end
    end

    // register writes on the last bit of a write frame
    if (sclk_rise && st_q.bit_cnt == pcc_pkg::LAST_BIT && !word[8]) begin
      unique case (waddr)
        pcc_pkg::ADDR_FRAC_LOW: st_d.frac_low = wdata; // RL4
        pcc_pkg::ADDR_FRAC_MID: st_d.frac_mid = wdata; // RL4
        pcc_pkg::ADDR_FRAC_HIGH: st_d.frac_high = wdata[5:0]; // RL4
        pcc_pkg::ADDR_INT_VALID: st_d.int_valid = wdata;
        pcc_pkg::ADDR_DIV_SELECT: st_d.div_select = wdata[5:0];
        default: ;
      endcase
      if (waddr == pcc_pkg::ADDR_RESET_ID_LOW) begin
        st_d = RST_STATE; // RL1 RL19
        st_d.sclk_prev = link.sclk;
        st_d.reset_pulse = 1'b1; // RL1
      end
    end

    // receive mode forces the post-divider
    if (rx_mode) begin
      st_d.div_select[pcc_pkg::POST_MSB:pcc_pkg::POST_LSB] =
        rx_post_divider; // RL11
    end

    // derived outputs
    st_d.frac_eff = st_d.div_select[pcc_pkg::FRAC_EN_BIT] ?
      {st_d.frac_high, st_d.frac_mid, st_d.frac_low} : 22'h000000; // RL12
    if (st_d.int_valid[pcc_pkg::VAL_OVR_BIT]) begin
      st_d.val_sf0 = st_d.int_valid[pcc_pkg::VAL_SF0_BIT]; // RL10
      st_d.val_sf1 = st_d.int_valid[pcc_pkg::VAL_SF1_BIT]; // RL10
    end else begin
      st_d.val_sf0 = tx_source_is_receiver & rx_validity; // RL9
      st_d.val_sf1 = tx_source_is_receiver & rx_validity; // RL9
    end
    st_d.mclk_osc = master_clock_out_source; // RL16
    st_d.aux_osc = aux_clock_source; // RL17
    st_d.mdiv_eff = ~master_clock_out_source &
      st_d.div_select[pcc_pkg::MDIV_BIT]; // RL14
    st_d.adiv_eff = aux_clock_source ? 2'h0 :
      st_d.div_select[pcc_pkg::ADIV_MSB:pcc_pkg::ADIV_LSB]; // RL15
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q <= RST_STATE;
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign link.dev_sdout = st_q.shift_out[7];
  assign link.dev_sdout_oe = st_q.reading & ~link.cs_n;
  assign device_reset_pulse = st_q.reset_pulse;
  assign pll_fraction = st_q.frac_eff;
  assign pll_integer = st_q.int_valid[pcc_pkg::INT_MSB:pcc_pkg::INT_LSB];
  assign pll_input_halver = st_q.int_valid[pcc_pkg::HALVER_BIT]; // RL8
  assign fractional_pll_enable = st_q.div_select[pcc_pkg::FRAC_EN_BIT];
  assign pll_post_divider_select =
    st_q.div_select[pcc_pkg::POST_MSB:pcc_pkg::POST_LSB]; // RL11
  assign master_clock_out_divider = st_q.mdiv_eff;
  assign aux_clock_out_divider = st_q.adiv_eff;
  assign tx_validity_first_subframe = st_q.val_sf0;
  assign tx_validity_second_subframe = st_q.val_sf1;
  assign master_clock_uses_osc = st_q.mclk_osc;
  assign aux_clock_uses_osc = st_q.aux_osc;

endmodule

// [pcc_pkg.sv]
// shared constants for the pll clock configuration link
package pcc_pkg;

  // ----------------------------------------------------------------
  // serial frame layout
  // ----------------------------------------------------------------
  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;
  localparam int FRAME_BITS = 16;
  localparam logic [3:0] LAST_BIT = 4'hf;
  localparam logic [3:0] RW_BIT = 4'h7;
  localparam logic [3:0] FIRST_DATA_BIT = 4'h8;

  // ----------------------------------------------------------------
  // register addresses
  // ----------------------------------------------------------------
  localparam logic [6:0] ADDR_RESET_ID_LOW = 7'h00;
  localparam logic [6:0] ADDR_ID_HIGH = 7'h01;
  localparam logic [6:0] ADDR_REVISION = 7'h02;
  localparam logic [6:0] ADDR_FRAC_LOW = 7'h03;
  localparam logic [6:0] ADDR_FRAC_MID = 7'h04;
  localparam logic [6:0] ADDR_FRAC_HIGH = 7'h05;
  localparam logic [6:0] ADDR_INT_VALID = 7'h06;
  localparam logic [6:0] ADDR_DIV_SELECT = 7'h07;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_FRAC_LOW = 8'h21;
  localparam logic [7:0] RST_FRAC_MID = 8'hfd;
  localparam logic [5:0] RST_FRAC_HIGH = 6'h36;
  localparam logic [7:0] RST_INT_VALID = 8'h07;
  localparam logic [5:0] RST_DIV_SELECT = 6'h16;

  // ----------------------------------------------------------------
  // identification, values arbitrary
  // ----------------------------------------------------------------
  localparam logic [7:0] ID_LOW_CODE = 8'h3c;
  localparam logic [7:0] ID_HIGH_CODE = 8'ha6;
  localparam logic [3:0] REVISION_CODE = 4'h1;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int INT_LSB = 0;
  localparam int INT_MSB = 3;
  localparam int HALVER_BIT = 4;
  localparam int VAL_SF0_BIT = 5;
  localparam int VAL_SF1_BIT = 6;
  localparam int VAL_OVR_BIT = 7;
  localparam int POST_LSB = 0;
  localparam int POST_MSB = 1;
  localparam int FRAC_EN_BIT = 2;
  localparam int MDIV_BIT = 3;
  localparam int ADIV_LSB = 4;
  localparam int ADIV_MSB = 5;
  localparam logic [7:0] MASK_SIX_BITS = 8'h3f;
  localparam logic [7:0] MASK_ALL_BITS = 8'hff;

  // ----------------------------------------------------------------
  // integer ratio advised range
  // ----------------------------------------------------------------
  localparam logic [3:0] INT_MIN = 4'h5;
  localparam logic [3:0] INT_MAX = 4'hd;

  // ----------------------------------------------------------------
  // serial clock timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 20_000_000;
  localparam int SCLK_HZ = 1_000_000;
  localparam int HALF_CYC = CLK_HZ / (2 * SCLK_HZ);
  localparam logic [7:0] HALF_CYC_M1 = 8'(HALF_CYC - 1);

endpackage

// [pcc_link_if.sv]
// serial control link between host and device
interface pcc_link_if;
  logic cs_n;
  logic sclk;
  logic sdin;
  logic dev_sdout;
  logic dev_sdout_oe;
  logic sdout;

  // shared data-out line, low when undriven
  assign sdout = dev_sdout_oe & dev_sdout;

  modport device (
    input cs_n,
    input sclk,
    input sdin,
    output dev_sdout,
    output dev_sdout_oe
  );

  modport host (
    output cs_n,
    output sclk,
    output sdin,
    input sdout
  );
endinterface

// [pcc_tick_div.sv]
// half-period tick divider for the serial clock
module pcc_tick_div (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run,
  output logic tick
);

  typedef struct packed {
    logic [7:0] cnt;
    logic tick;
  } pcc_div_st_t;

  pcc_div_st_t st_q;
  pcc_div_st_t st_d;

  always_comb begin
    st_d = st_q;
    st_d.tick = 1'b0;
    if (!run) begin
      st_d.cnt = 8'h00;
    end else if (st_q.cnt == pcc_pkg::HALF_CYC_M1) begin
      st_d.cnt = 8'h00;
      st_d.tick = 1'b1;
    end else begin
      st_d.cnt = st_q.cnt + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign tick = st_q.tick;

endmodule

// [pcc_host.sv]
// host end: issues register reads and writes over the serial link
module pcc_host (
  input wire logic clk,
  input wire logic rst_n,
  pcc_link_if.host link,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [6:0] req_addr,
  input wire logic [7:0] req_wdata,
  input wire logic rx_in_use,
  input wire logic [21:0] rx_required_fraction,
  input wire logic [3:0] rx_required_integer,
  output logic req_ready,
  output logic req_rejected,
  output logic done,
  output logic [7:0] rdata
);

  typedef enum logic [2:0] {IDLE, SETUP, LOW, HIGH, STOP} pcc_host_state_t;

  typedef struct packed {
    pcc_host_state_t state;
    logic [15:0] frame;
    logic [3:0] bit_cnt;
    logic reading;
    logic [7:0] rx_shift;
    logic [7:0] rdata;
    logic cs_n;
    logic sclk;
    logic done;
    logic rejected;
  } pcc_host_st_t;

  pcc_host_st_t st_q;
  pcc_host_st_t st_d;
  logic tick;
  logic bad;
  logic [7:0] wmask;

  pcc_tick_div u_div (
    .clk(clk),
    .rst_n(rst_n),
    .run(st_q.state != IDLE),
    .tick(tick)
  );

  // ----------------------------------------------------------------
  // request screening
  // ----------------------------------------------------------------
  always_comb begin
    bad = 1'b0;
    wmask = pcc_pkg::MASK_ALL_BITS;
    unique case (req_addr)
      pcc_pkg::ADDR_RESET_ID_LOW: wmask = 8'h00; // RL18
      pcc_pkg::ADDR_FRAC_LOW:
        bad = rx_in_use && req_wdata != rx_required_fraction[7:0]; // RL5
      pcc_pkg::ADDR_FRAC_MID:
        bad = rx_in_use && req_wdata != rx_required_fraction[15:8]; // RL5
      pcc_pkg::ADDR_FRAC_HIGH: begin
        wmask = pcc_pkg::MASK_SIX_BITS; // RL18
        bad = rx_in_use &&
          req_wdata[5:0] != rx_required_fraction[21:16]; // RL5
      end
      pcc_pkg::ADDR_INT_VALID: begin
        bad = req_wdata[3:0] < pcc_pkg::INT_MIN ||
          req_wdata[3:0] > pcc_pkg::INT_MAX; // RL6
        if (rx_in_use && req_wdata[3:0] != rx_required_integer) begin
          bad = 1'b1; // RL7
        end
      end
      pcc_pkg::ADDR_DIV_SELECT: begin
        wmask = pcc_pkg::MASK_SIX_BITS; // RL18
        bad = rx_in_use && !req_wdata[pcc_pkg::FRAC_EN_BIT]; // RL13
      end
      default: ;
    endcase
    if (!req_write) begin
      bad = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // frame sequencer
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    st_d.done = 1'b0;
    st_d.rejected = 1'b0;
    unique case (st_q.state)
      IDLE: begin
        if (req_valid && bad) begin
          st_d.rejected = 1'b1;
        end else if (req_valid) begin
          st_d.frame = {req_addr, ~req_write, req_wdata & wmask};
          st_d.reading = ~req_write;
          st_d.bit_cnt = 4'h0;
          st_d.cs_n = 1'b0;
          st_d.state = SETUP;
        end
      end
      SETUP: begin
        if (tick) begin
          st_d.state = LOW;
        end
      end
      LOW: begin
        if (tick) begin
          if (st_q.reading && st_q.bit_cnt >= pcc_pkg::FIRST_DATA_BIT) begin
            st_d.rx_shift = {st_q.rx_shift[6:0], link.sdout};
          end
          st_d.sclk = 1'b1;
          st_d.state = HIGH;
        end
      end
      HIGH: begin
        if (tick) begin
          st_d.sclk = 1'b0;
          if (st_q.bit_cnt == pcc_pkg::LAST_BIT) begin
            st_d.state = STOP;
          end else begin
            st_d.bit_cnt = st_q.bit_cnt + 4'h1;
            st_d.frame = {st_q.frame[14:0], 1'b0};
            st_d.state = LOW;
          end
        end
      end
      STOP: begin
        st_d.cs_n = 1'b1;
        st_d.done = 1'b1;
        if (st_q.reading) begin
          st_d.rdata = st_q.rx_shift;
        end
        st_d.state = IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q <= '{state: IDLE, frame: 16'h0000, bit_cnt: 4'h0, reading: 1'b0,
                rx_shift: 8'h00, rdata: 8'h00, cs_n: 1'b1, sclk: 1'b0,
                done: 1'b0, rejected: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  assign link.cs_n = st_q.cs_n;
  assign link.sclk = st_q.sclk;
  assign link.sdin = st_q.frame[15];
  assign req_ready = (st_q.state == IDLE);
  assign req_rejected = st_q.rejected;
  assign done = st_q.done;
  assign rdata = st_q.rdata;

endmodule

// [pcc_monitor.sv]
// checker for the serial link and the device outputs
module pcc_monitor (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic dev_sdout_oe,
  input wire logic device_reset_pulse,
  input wire logic [21:0] pll_fraction,
  input wire logic [3:0] pll_integer,
  input wire logic fractional_pll_enable,
  input wire logic master_clock_out_divider,
  input wire logic master_clock_uses_osc,
  input wire logic [1:0] aux_clock_out_divider,
  input wire logic aux_clock_uses_osc,
  input wire logic rx_mode,
  input wire logic [1:0] rx_post_divider,
  input wire logic [1:0] pll_post_divider_select
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  read_oe_frame_a: assert property (
    $fell(cs_n) |-> !dev_sdout_oe[*8])
    else $error("read data driven before the address");
  read_oe_hold_a: assert property (
    $rose(dev_sdout_oe) |-> dev_sdout_oe[*8])
    else $error("read data phase cut short");
  reset_single_a: assert property (
    device_reset_pulse |=> !device_reset_pulse)
    else $error("reset pulse longer than one cycle");
  reset_in_frame_a: assert property (
    device_reset_pulse |-> !cs_n && sclk)
    else $error("reset pulse without a write frame");
  reset_defaults_a: assert property (
    device_reset_pulse |-> ##[0:3]
      (pll_integer == 4'h7 && pll_fraction == 22'h36fd21))
    else $error("registers not back to defaults");
  frac_off_zero_a: assert property (
    !fractional_pll_enable |-> pll_fraction == 22'h0)
    else $error("fraction used in integer mode");
  master_div_gate_a: assert property (
    master_clock_uses_osc |-> !master_clock_out_divider)
    else $error("master divider active on oscillator");
  aux_div_gate_a: assert property (
    aux_clock_uses_osc |-> aux_clock_out_divider == 2'h0)
    else $error("aux divider active on oscillator");
  rx_post_force_a: assert property (
    $past(rx_mode, 2) && $past(rx_mode) && $stable(rx_post_divider)
      && $past(rx_post_divider, 2) == rx_post_divider
      |-> pll_post_divider_select == rx_post_divider)
    else $error("post divider not set in receive mode");

  cover property ($rose(dev_sdout_oe));
  cover property (device_reset_pulse);
  cover property (rx_mode && $past(rx_mode, 2));
endmodule

// [pll_clock_config_registers_bench.sv]
// self-checking bench for the host and device ends
module pll_clock_config_registers_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst_n, req_valid, req_write, rx_in_use, req_ready;
  logic req_rejected, done, rx_mode, tx_source_is_receiver;
  logic rx_validity, master_clock_out_source, aux_clock_source;
  logic device_reset_pulse, pll_input_halver, fractional_pll_enable;
  logic master_clock_out_divider, tx_validity_first_subframe;
  logic tx_validity_second_subframe, master_clock_uses_osc;
  logic aux_clock_uses_osc, rej, seen_rst;
  logic [6:0] req_addr;
  logic [7:0] req_wdata, rdata, v, p;
  logic [21:0] rx_required_fraction, pll_fraction, f;
  logic [3:0] rx_required_integer, pll_integer;
  logic [1:0] rx_post_divider, pll_post_divider_select;
  logic [1:0] aux_clock_out_divider;
  logic [3:0] bad [4] = '{4'h0, 4'h4, 4'he, 4'hf};
  int mismatches, cmp_count, cycles;

  pcc_link_if i_pcc_link_if ();
  pcc_host i_pcc_host (.clk, .rst_n, .link(i_pcc_link_if.host),
    .req_valid, .req_write, .req_addr, .req_wdata, .rx_in_use,
    .rx_required_fraction, .rx_required_integer, .req_ready,
    .req_rejected, .done, .rdata);
  pcc_device i_pcc_device (.clk, .rst_n, .link(i_pcc_link_if.device),
    .rx_mode, .rx_post_divider, .tx_source_is_receiver, .rx_validity,
    .master_clock_out_source, .aux_clock_source, .device_reset_pulse,
    .pll_fraction, .pll_integer, .pll_input_halver,
    .fractional_pll_enable, .pll_post_divider_select,
    .master_clock_out_divider, .aux_clock_out_divider,
    .tx_validity_first_subframe, .tx_validity_second_subframe,
    .master_clock_uses_osc, .aux_clock_uses_osc);
  pcc_monitor i_pcc_monitor (.clk, .rst_n, .cs_n(i_pcc_link_if.cs_n),
    .sclk(i_pcc_link_if.sclk), .dev_sdout_oe(i_pcc_link_if.dev_sdout_oe),
    .device_reset_pulse, .pll_fraction, .pll_integer,
    .fractional_pll_enable, .master_clock_out_divider,
    .master_clock_uses_osc, .aux_clock_out_divider, .aux_clock_uses_osc,
    .rx_mode, .rx_post_divider, .pll_post_divider_select);

  // ----------------------------------------
  // clock, timeout, helpers
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (device_reset_pulse === 1'b1) seen_rst <= 1'b1;
    if (cycles == 30000) begin
      mismatches++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("compares %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic ok, input string msg);
    cmp_count++;
    if (!ok) begin
      mismatches++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask

  // one request, rd high for a read, waits for done or refusal
  task automatic xfer(input logic rd, input logic [6:0] a,
      input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    req_valid <= 1'b1;
    req_write <= ~rd;
    req_addr <= a;
    req_wdata <= d;
    @(posedge clk);
    req_valid <= 1'b0;
    // refusal pulse stands only in the cycle after the take
    #1;
    while (done !== 1'b1 && req_rejected !== 1'b1 && n < 400) begin
      @(posedge clk);
      #1;
      n++;
    end
    rej = req_rejected;
    if (n >= 400) chk(1'b0, "no answer from host");
    repeat (3) @(posedge clk);
  endtask

  function automatic logic [1:0] exp_val(logic [7:0] r, logic s,
      logic rv);
    if (r[7]) return {r[5], r[6]};
    return s ? {rv, rv} : 2'b00;
  endfunction

  task automatic check_defaults();
    chk(pll_fraction === 22'h36fd21, "fraction default");
    chk({pll_input_halver, pll_integer} === 5'h07, "0x06 default");
    chk({aux_clock_out_divider, master_clock_out_divider,
      fractional_pll_enable, pll_post_divider_select} === 6'h16,
      "0x07 default");
    chk({tx_validity_first_subframe, tx_validity_second_subframe}
      === 2'b00, "validity default");
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {rst_n, req_valid, req_write, req_addr, req_wdata, rx_in_use} = '0;
    {rx_required_fraction, rx_required_integer, rx_mode} = '0;
    {rx_post_divider, tx_source_is_receiver, rx_validity} = '0;
    {master_clock_out_source, aux_clock_source, seen_rst} = '0;
    void'($urandom(82824));
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    check_defaults();
    $display("test defaults done");

    xfer(1'b1, 7'h00, 8'h00);
    chk(rdata === pcc_pkg::ID_LOW_CODE, "id low");
    xfer(1'b0, 7'h01, 8'h5a);
    xfer(1'b1, 7'h01, 8'h00);
    chk(rdata === pcc_pkg::ID_HIGH_CODE, "id high");
    xfer(1'b1, 7'h02, 8'h00);
    chk(rdata === {4'h0, pcc_pkg::REVISION_CODE}, "revision");
    $display("test identity done");

    for (int i = 0; i < 4; i++) begin
      f = (i == 0) ? 22'h3fffff : 22'($urandom());
      xfer(1'b0, 7'h03, f[7:0]);
      xfer(1'b0, 7'h04, f[15:8]);
      xfer(1'b0, 7'h05, {2'b00, f[21:16]});
      chk(pll_fraction === f, "fraction");
    end
    $display("test fraction done");

    for (int i = 0; i < 8; i++) begin
      v = 8'($urandom());
      v[7] = i[0];
      v[3:0] = (i == 0) ? 4'h5 : (i == 1) ? 4'hd : 4'(5 + $urandom % 9);
      p = {2'b00, 6'($urandom())};
      tx_source_is_receiver <= 1'($urandom());
      rx_validity <= 1'($urandom());
      master_clock_out_source <= 1'($urandom());
      aux_clock_source <= 1'($urandom());
      xfer(1'b0, 7'h06, v);
      xfer(1'b0, 7'h07, p);
      chk(pll_integer === v[3:0], "integer");
      chk(pll_input_halver === v[4], "halver");
      chk({tx_validity_first_subframe, tx_validity_second_subframe} ===
        exp_val(v, tx_source_is_receiver, rx_validity), "valid");
      chk(pll_fraction === (p[2] ? f : 22'h0), "frac mode");
      chk(pll_post_divider_select === p[1:0], "post div");
      chk(master_clock_out_divider ===
        (!master_clock_out_source & p[3]), "master div");
      chk(aux_clock_out_divider ===
        (aux_clock_source ? 2'b00 : p[5:4]), "aux div");
      chk({master_clock_uses_osc, aux_clock_uses_osc} ===
        {master_clock_out_source, aux_clock_source}, "sources");
    end
    $display("test control fields done");

    for (int k = 0; k < 4; k++) begin
      xfer(1'b0, 7'h06, {4'h0, bad[k]});
      chk(rej === 1'b1 && pll_integer === v[3:0], "range");
    end
    rx_in_use <= 1'b1;
    rx_required_fraction <= f ^ 22'h1;
    rx_required_integer <= 4'h8;
    xfer(1'b0, 7'h03, f[7:0]);
    chk(rej === 1'b1, "rx fraction");
    xfer(1'b0, 7'h06, 8'h09);
    chk(rej === 1'b1, "rx integer");
    xfer(1'b0, 7'h07, 8'h10);
    chk(rej === 1'b1, "rx frac off");
    xfer(1'b0, 7'h06, 8'h08);
    chk(rej === 1'b0 && pll_integer === 4'h8, "rx integer ok");
    rx_mode <= 1'b1;
    rx_post_divider <= 2'($urandom());
    repeat (4) @(posedge clk);
    chk(pll_post_divider_select === rx_post_divider, "rx post");
    rx_mode <= 1'b0;
    rx_in_use <= 1'b0;
    $display("test refusals done");

    master_clock_out_source <= 1'b0;
    aux_clock_source <= 1'b0;
    tx_source_is_receiver <= 1'b0;
    xfer(1'b0, 7'h00, 8'($urandom()));
    chk(seen_rst === 1'b1, "reset pulse");
    check_defaults();
    $display("test soft reset done");
    wrap_up();
  end
endmodule
